// File: rtl/acd_pkg.sv
package acd_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    // Base of the register block in processor space (arbitrary value)
    localparam logic [15:0] BLOCK_BASE   = 16'h0000;
    localparam logic [15:0] ADDR_STATUS  = BLOCK_BASE + 16'h0080;
    localparam logic [15:0] ADDR_CTRL    = BLOCK_BASE + 16'h0082;
    localparam logic [15:0] ADDR_DIN     = BLOCK_BASE + 16'h0084;
    localparam logic [15:0] ADDR_DOUT    = BLOCK_BASE + 16'h0086;

    localparam logic [1:0]  SEL_STATUS   = 2'h0;
    localparam logic [1:0]  SEL_CTRL     = 2'h1;
    localparam logic [1:0]  SEL_DIN      = 2'h2;
    localparam logic [1:0]  SEL_DOUT     = 2'h3;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_GATE   = 7;
    localparam int CTRL_INT_EN = 6;
    localparam int CTRL_START  = 5;
    localparam int CTRL_USER_H = 4;
    localparam int STAT_DONE   = 7;
    localparam int STAT_ERR    = 6;
    localparam int STAT_INTR   = 5;
    localparam int STAT_EMPTY  = 4;
    localparam int STAT_FULL   = 3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [7:0]  DIN_RST      = 8'h00;
    localparam logic [7:0]  DOUT_RST     = 8'h00;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;
    localparam logic [7:0]  PIN_IDLE     = 8'hFF;

    // ------------------------------------------------------------------
    // Bus cycle states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_DATA,
        BUS_END
    } acd_bus_state_t;

endpackage : acd_pkg

// File: rtl/acd_bus.sv
`timescale 1ns/1ns
module acd_bus (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // Processor pins
    input  wire logic        ale_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [7:0]  addr_hi,
    input  wire logic [7:0]  port0_in,
    // Cycle outputs
    output logic [15:0]      bus_addr,
    output logic [7:0]       bus_wdata,
    output logic             bus_wr,
    output logic             bus_rd,
    output logic             bus_read_phase
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                    ale_m;
        logic                    ale_s;
        logic                    rd_m;
        logic                    rd_s;
        logic                    wr_m;
        logic                    wr_s;
        logic [7:0]              dat_m;
        logic [7:0]              dat_s;
        logic [7:0]              ahi_m;
        logic [7:0]              ahi_s;
        acd_pkg::acd_bus_state_t st;
        logic                    is_read;
        logic [15:0]             addr;
        logic [7:0]              wdata;
        logic                    wr_p;
        logic                    rd_p;
    } acd_bus_state_s_t;

    acd_bus_state_s_t st_r;
    acd_bus_state_s_t st_nxt;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt       = st_r;
        st_nxt.ale_m = ale_n;
        st_nxt.ale_s = st_r.ale_m;
        st_nxt.rd_m  = rd_n;
        st_nxt.rd_s  = st_r.rd_m;
        st_nxt.wr_m  = wr_n;
        st_nxt.wr_s  = st_r.wr_m;
        st_nxt.dat_m = port0_in;
        st_nxt.dat_s = st_r.dat_m;
        st_nxt.ahi_m = addr_hi;
        st_nxt.ahi_s = st_r.ahi_m;
        st_nxt.wr_p  = 1'b0;
        st_nxt.rd_p  = 1'b0;
        case (st_r.st)
            acd_pkg::BUS_IDLE: begin
                if (!st_r.ale_s) begin
                    st_nxt.addr = {st_r.ahi_s, st_r.dat_s};
                    st_nxt.st   = acd_pkg::BUS_ADDR;
                end
            end
            acd_pkg::BUS_ADDR: begin
                if (!st_r.wr_s) begin
                    st_nxt.wdata   = st_r.dat_s;
                    st_nxt.wr_p    = 1'b1;
                    st_nxt.is_read = 1'b0;
                    st_nxt.st      = acd_pkg::BUS_DATA;
                end else if (!st_r.rd_s) begin
                    st_nxt.rd_p    = 1'b1;
                    st_nxt.is_read = 1'b1;
                    st_nxt.st      = acd_pkg::BUS_DATA;
                end else if (st_r.ale_s) begin
                    st_nxt.st      = acd_pkg::BUS_IDLE;
                end
            end
            acd_pkg::BUS_DATA: begin
                if (st_r.is_read ? st_r.rd_s : st_r.wr_s) begin
                    st_nxt.st = acd_pkg::BUS_END;
                end
            end
            acd_pkg::BUS_END: begin
                if (st_r.ale_s) begin
                    st_nxt.st = acd_pkg::BUS_IDLE;
                end
            end
            default: begin
                st_nxt.st = acd_pkg::BUS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            st_r         <= '0;
            st_r.ale_m   <= 1'b1;
            st_r.ale_s   <= 1'b1;
            st_r.rd_m    <= 1'b1;
            st_r.rd_s    <= 1'b1;
            st_r.wr_m    <= 1'b1;
            st_r.wr_s    <= 1'b1;
            st_r.st      <= acd_pkg::BUS_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus_addr       = st_r.addr;
    assign bus_wdata      = st_r.wdata;
    assign bus_wr         = st_r.wr_p;
    assign bus_rd         = st_r.rd_p;
    assign bus_read_phase = (st_r.st == acd_pkg::BUS_DATA) && st_r.is_read;

endmodule : acd_bus

// File: rtl/acd_regs.sv
//
// Overview of operation
// - Control register is eight bits, fully writable and read back.
// - Bit 7 gates interrupt enable, start and user bits.
// - Bit 7 low holds application in reset; high releases it.
// - Bit 6 high raises interrupt request while pending bit is set.
// - Clearing bit 6 masks only; pending cause and flag stay.
// - Start bit 0-to-1 write launches one operation; held 1 does not.
// - Bits 4..0 stored, read back and presented to application.
// - Input byte register written, read back, fed to application.
// - Output byte holds application result; processor writes ignored.
// - Input-empty flag set when no unconsumed byte; write clears it.
// - Output-full flag set on result load; processor read clears it.
//
`timescale 1ns/1ns
module acd_regs (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // Processor bus pins
    input  wire logic        ale_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [7:0]  addr_hi,
    input  wire logic [7:0]  port0_in,
    output logic      [7:0]  port0_out,
    output logic             port0_oe,
    output logic             irq_n,
    // Application side
    output logic             app_reset,
    output logic             app_launch,
    output logic      [4:0]  app_user_bits,
    output logic      [7:0]  app_operand,
    input  wire logic [7:0]  app_result,
    input  wire logic        app_result_load,
    input  wire logic        app_done,
    input  wire logic        app_error,
    input  wire logic        app_intr
);

    // ------------------------------------------------------------------
    // Bus cycle front end
    // ------------------------------------------------------------------
    logic [15:0] bus_addr;
    logic [7:0]  bus_wdata;
    logic        bus_wr;
    logic        bus_rd;
    logic        bus_read_phase;

    acd_bus u_bus (
        .clock          (clock),
        .reset          (reset),
        .ale_n          (ale_n),
        .rd_n           (rd_n),
        .wr_n           (wr_n),
        .addr_hi        (addr_hi),
        .port0_in       (port0_in),
        .bus_addr       (bus_addr),
        .bus_wdata      (bus_wdata),
        .bus_wr         (bus_wr),
        .bus_rd         (bus_rd),
        .bus_read_phase (bus_read_phase)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic [2:0] reg_decode(input logic [15:0] a);
        case (a)
            acd_pkg::ADDR_STATUS: reg_decode = {1'b1, acd_pkg::SEL_STATUS};
            acd_pkg::ADDR_CTRL:   reg_decode = {1'b1, acd_pkg::SEL_CTRL};
            acd_pkg::ADDR_DIN:    reg_decode = {1'b1, acd_pkg::SEL_DIN};
            acd_pkg::ADDR_DOUT:   reg_decode = {1'b1, acd_pkg::SEL_DOUT};
            default:              reg_decode = 3'h0;
        endcase
    endfunction : reg_decode

    logic [2:0] dec;
    logic       wr_ctrl;
    logic       wr_din;
    logic       wr_stat;
    logic       rd_hit;
    logic       rd_dout;

    assign dec     = reg_decode(bus_addr);
    assign wr_ctrl = bus_wr && (dec == {1'b1, acd_pkg::SEL_CTRL});
    assign wr_din  = bus_wr && (dec == {1'b1, acd_pkg::SEL_DIN});
    assign wr_stat = bus_wr && (dec == {1'b1, acd_pkg::SEL_STATUS});
    assign rd_hit  = bus_rd && dec[2];
    assign rd_dout = bus_rd && (dec == {1'b1, acd_pkg::SEL_DOUT});

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] din;
        logic [7:0] dout;
        logic       empty;
        logic       full;
        logic       intr;
        logic       err;
        logic       launch;
        logic       irq_n;
        logic       drive;
        logic [7:0] rdata;
    } acd_regs_state_t;

    acd_regs_state_t st_r;
    acd_regs_state_t st_nxt;

    logic gate_nxt;
    logic load_ok;
    logic [7:0] status_byte;

    assign load_ok     = app_result_load && st_r.ctrl[acd_pkg::CTRL_GATE];
    assign status_byte = {app_done, st_r.err, st_r.intr, st_r.empty,
                          st_r.full, 3'h0};

    always_comb begin
        st_nxt        = st_r;
        st_nxt.launch = 1'b0;
        gate_nxt      = st_r.ctrl[acd_pkg::CTRL_GATE];
        if (wr_ctrl) begin
            st_nxt.ctrl = bus_wdata;
            gate_nxt    = bus_wdata[acd_pkg::CTRL_GATE];
            if (gate_nxt && bus_wdata[acd_pkg::CTRL_START] &&
                !st_r.ctrl[acd_pkg::CTRL_START]) begin
                st_nxt.launch = 1'b1;
                st_nxt.empty  = 1'b1;
            end
        end
        if (wr_din) begin
            st_nxt.din   = bus_wdata;
            st_nxt.empty = 1'b0;
        end
        // Software clears by writing 0; a same-cycle event wins
        if (wr_stat && !bus_wdata[acd_pkg::STAT_ERR]) begin
            st_nxt.err = 1'b0;
        end
        if (wr_stat && !bus_wdata[acd_pkg::STAT_INTR]) begin
            st_nxt.intr = 1'b0;
        end
        if (rd_dout) begin
            st_nxt.full = 1'b0;
        end
        if (st_r.ctrl[acd_pkg::CTRL_GATE]) begin
            if (app_error) begin
                st_nxt.err = 1'b1;
            end
            if (app_intr) begin
                st_nxt.intr = 1'b1;
            end
        end
        if (load_ok) begin
            st_nxt.dout = app_result;
            st_nxt.full = 1'b1;
        end
        // Masking leaves the pending flag untouched
        st_nxt.irq_n = !(gate_nxt && st_nxt.ctrl[acd_pkg::CTRL_INT_EN] &&
                         st_nxt.intr);
        // Never carry a stale drive into the next read cycle
        if (!bus_read_phase) begin
            st_nxt.drive = 1'b0;
        end
        if (bus_rd) begin
            st_nxt.drive = dec[2];
            case (dec[1:0])
                acd_pkg::SEL_STATUS: st_nxt.rdata = status_byte;
                acd_pkg::SEL_CTRL:   st_nxt.rdata = st_r.ctrl;
                acd_pkg::SEL_DIN:    st_nxt.rdata = st_r.din;
                acd_pkg::SEL_DOUT:   st_nxt.rdata = st_r.dout;
                default:             st_nxt.rdata = acd_pkg::BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_r       <= '0;
            st_r.ctrl  <= acd_pkg::CTRL_RST;
            st_r.din   <= acd_pkg::DIN_RST;
            st_r.dout  <= acd_pkg::DOUT_RST;
            st_r.empty <= 1'b1;
            st_r.irq_n <= 1'b1;
            st_r.rdata <= acd_pkg::PIN_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign port0_out     = st_r.rdata;
    assign port0_oe      = bus_read_phase && st_r.drive;
    assign irq_n         = st_r.irq_n;
    assign app_reset     = !st_r.ctrl[acd_pkg::CTRL_GATE];
    assign app_launch    = st_r.launch;
    assign app_user_bits = st_r.ctrl[acd_pkg::CTRL_GATE] ?
                           st_r.ctrl[acd_pkg::CTRL_USER_H:0] :
                           5'h00;
    assign app_operand   = st_r.din;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_ctrl_write_back: assert property (
        wr_ctrl |=> st_r.ctrl == $past(bus_wdata))
        else $error("control register differs from written value");
    a_ctrl_read_back: assert property (
        (bus_rd && dec == {1'b1, acd_pkg::SEL_CTRL})
        |=> port0_out == $past(st_r.ctrl))
        else $error("control readback differs from stored value");
    a_gate_blocks_launch: assert property (
        app_launch |-> !app_reset)
        else $error("launch while application held in reset");
    a_gate_low_reset: assert property (
        (wr_ctrl && !bus_wdata[7]) |=> app_reset && app_user_bits == 5'h00)
        else $error("application not held in reset");
    a_irq_raised: assert property (
        (st_r.ctrl[7] && st_r.ctrl[6] && st_r.intr) |-> !irq_n)
        else $error("interrupt request missing");
    a_mask_keeps_cause: assert property (
        (st_r.intr && wr_ctrl && !bus_wdata[6]) |=> st_r.intr && irq_n)
        else $error("masking changed pending flag");
    a_start_one_shot: assert property (
        (wr_ctrl && !st_r.ctrl[5] && bus_wdata[7] && bus_wdata[5])
        |=> app_launch ##1 !app_launch)
        else $error("start edge did not give one launch");
    a_start_no_relaunch: assert property (
        (wr_ctrl && st_r.ctrl[5]) |=> !app_launch)
        else $error("held start relaunched");
    a_din_stored: assert property (
        wr_din |=> app_operand == $past(bus_wdata) && !st_r.empty)
        else $error("input byte not stored");
    a_dout_read_only: assert property (
        (bus_wr && dec == {1'b1, acd_pkg::SEL_DOUT} && !load_ok)
        |=> $stable(st_r.dout))
        else $error("processor write changed output byte");
    a_full_on_load: assert property (
        load_ok |=> st_r.full && st_r.dout == $past(app_result))
        else $error("result load not flagged");
    a_empty_on_launch: assert property (
        app_launch |-> st_r.empty)
        else $error("input not marked consumed");

    c_launch:  cover property (wr_din ##[1:200] app_launch);
    c_irq:     cover property ($fell(irq_n));
    c_read_out: cover property (load_ok ##[1:400] rd_dout);

endmodule : acd_regs

// File: dv/acd_app_model.sv
`timescale 1ns/1ns
module acd_app_model (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // From the register block
    input  wire logic       app_reset,
    input  wire logic       app_launch,
    input  wire logic [7:0] app_operand,
    // To the register block
    output logic      [7:0] app_result,
    output logic            app_result_load,
    output logic            app_done,
    output logic            app_error,
    output logic            app_intr,
    // Bench controls
    input  wire logic       slow,
    input  wire logic       fire_intr,
    input  wire logic       fire_err,
    output int              launches
);
    int cnt;

    // ------------------------------------------------------------------
    // Application stand-in: swap nibbles and mix, prompt or slow
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        app_result_load <= 1'h0;
        app_result      <= ~app_result;
        app_intr        <= fire_intr;
        app_error       <= fire_err;
        if (reset) begin
            cnt        <= 0;
            launches   <= 0;
            app_done   <= 1'h1;
            app_result <= 8'h00;
        end else if (app_reset) begin
            cnt <= 0;
        end else if (app_launch) begin
            launches <= launches + 1;
            cnt      <= slow ? 9 : 2;
            app_done <= 1'h0;
        end else if (cnt == 1) begin
            app_result      <= {app_operand[3:0], app_operand[7:4]} ^ 8'h5A;
            app_result_load <= 1'h1;
            app_done        <= 1'h1;
            cnt             <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule : acd_app_model

// File: dv/tb_app_control_data_registers.sv
`timescale 1ns/1ns
module tb_app_control_data_registers;
    logic       clock, reset, ale_n, rd_n, wr_n, port0_oe, irq_n;
    logic [7:0] addr_hi, p0_host, p0_pin, port0_out, app_operand, app_result;
    logic       app_reset, app_launch, app_result_load, app_done;
    logic       app_error, app_intr, slow, fire_intr, fire_err;
    logic [4:0] app_user_bits;
    logic [7:0] m_din, m_dout, v, d;
    logic       m_empty, m_full, m_pend, m_err, oe;
    int         launches, m_launch, n_errors, num_checks, seed;
    logic [7:0] exp_q[$];

    // Wire level of the shared address/data port
    assign p0_pin = port0_oe ? port0_out : p0_host;

    acd_regs dut (.clock(clock), .reset(reset), .ale_n(ale_n), .rd_n(rd_n),
        .wr_n(wr_n), .addr_hi(addr_hi), .port0_in(p0_pin),
        .port0_out(port0_out), .port0_oe(port0_oe), .irq_n(irq_n),
        .app_reset(app_reset), .app_launch(app_launch),
        .app_user_bits(app_user_bits), .app_operand(app_operand),
        .app_result(app_result), .app_result_load(app_result_load),
        .app_done(app_done), .app_error(app_error), .app_intr(app_intr));

    acd_app_model app (.clock(clock), .reset(reset), .app_reset(app_reset),
        .app_launch(app_launch), .app_operand(app_operand),
        .app_result(app_result), .app_result_load(app_result_load),
        .app_done(app_done), .app_error(app_error), .app_intr(app_intr),
        .slow(slow), .fire_intr(fire_intr), .fire_err(fire_err),
        .launches(launches));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic bus_write(logic [15:0] a, logic [7:0] dat);
        ale_n   <= 1'h0;
        addr_hi <= a[15:8];
        p0_host <= a[7:0];
        repeat (4) @(posedge clock);
        wr_n    <= 1'h0;
        p0_host <= dat;
        repeat (4) @(posedge clock);
        wr_n    <= 1'h1;
        repeat (4) @(posedge clock);
        ale_n   <= 1'h1;
        p0_host <= ~dat;
        repeat (4) @(posedge clock);
    endtask : bus_write

    task automatic bus_read(logic [15:0] a, output logic [7:0] q,
                            output logic o);
        ale_n   <= 1'h0;
        addr_hi <= a[15:8];
        p0_host <= a[7:0];
        repeat (4) @(posedge clock);
        rd_n    <= 1'h0;
        p0_host <= 8'($random(seed));
        repeat (6) @(posedge clock);
        @(negedge clock);
        q = p0_pin;
        o = port0_oe;
        @(posedge clock);
        rd_n    <= 1'h1;
        repeat (4) @(posedge clock);
        ale_n   <= 1'h1;
        repeat (4) @(posedge clock);
    endtask : bus_read

    task automatic rd(logic [15:0] a, logic [7:0] exp);
        logic [7:0] q;
        logic       o;
        bus_read(a, q, o);
        check("read data", exp, q);
        check("read drive", 8'h01, {7'h00, o});
    endtask : rd

    function automatic logic [7:0] stat();
        return {1'h1, m_err, m_pend, m_empty, m_full, 3'h0};
    endfunction : stat

    task automatic model_reset();
        m_din    = 8'h00;
        m_dout   = 8'h00;
        m_empty  = 1'h1;
        m_full   = 1'h0;
        m_pend   = 1'h0;
        m_err    = 1'h0;
        m_launch = 0;
    endtask : model_reset

    task automatic check_reset_state();
        rd(acd_pkg::ADDR_CTRL, 8'h00);
        rd(acd_pkg::ADDR_DIN, 8'h00);
        rd(acd_pkg::ADDR_DOUT, 8'h00);
        rd(acd_pkg::ADDR_STATUS, stat());
        check("app_reset", 8'h01, {7'h00, app_reset});
    endtask : check_reset_state

    task automatic pulse_flags();
        fire_intr <= 1'h1;
        fire_err  <= 1'h1;
        @(posedge clock);
        fire_intr <= 1'h0;
        fire_err  <= 1'h0;
        repeat (5) @(posedge clock);
    endtask : pulse_flags

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end

    initial begin
        #(100 * 20000);
        n_errors++;
        final_report();
    end

    initial begin
        seed = 5554;
        {reset, ale_n, rd_n, wr_n} = 4'hF;
        {addr_hi, p0_host} = 16'h0000;
        {slow, fire_intr, fire_err} = 3'h0;
        n_errors = 0;
        num_checks = 0;
        model_reset();
        repeat (3) @(posedge clock);
        reset <= 1'h0;
        check_reset_state();
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed)) & 8'h7F;
            bus_write(acd_pkg::ADDR_CTRL, v);
            rd(acd_pkg::ADDR_CTRL, v);
            check("user bits", 8'h00, {3'h0, app_user_bits});
            check("app_reset", 8'h01, {7'h00, app_reset});
        end
        check("launches", 8'h00, launches[7:0]);
        for (int i = 0; i < 4; i++) begin
            slow  <= i[0];
            m_din = 8'($random(seed));
            v     = 8'($random(seed)) & 8'h1F;
            bus_write(acd_pkg::ADDR_DIN, m_din);
            m_empty = 1'h0;
            rd(acd_pkg::ADDR_DIN, m_din);
            check("operand", m_din, app_operand);
            rd(acd_pkg::ADDR_STATUS, stat());
            bus_write(acd_pkg::ADDR_CTRL, 8'h80 | v);
            check("user bits", v, {3'h0, app_user_bits});
            check("app_reset", 8'h00, {7'h00, app_reset});
            bus_write(acd_pkg::ADDR_CTRL, 8'hA0 | v);
            m_launch++;
            exp_q.push_back({m_din[3:0], m_din[7:4]} ^ 8'h5A);
            m_empty = 1'h1;
            repeat (12) @(posedge clock);
            m_dout = exp_q.pop_front();
            m_full = 1'h1;
            rd(acd_pkg::ADDR_STATUS, stat());
            rd(acd_pkg::ADDR_CTRL, 8'hA0 | v);
            bus_write(acd_pkg::ADDR_CTRL, 8'hA0 | v);
            repeat (12) @(posedge clock);
            check("launches", m_launch[7:0], launches[7:0]);
            bus_write(acd_pkg::ADDR_DOUT, ~m_dout);
            rd(acd_pkg::ADDR_DOUT, m_dout);
            m_full = 1'h0;
            rd(acd_pkg::ADDR_STATUS, stat());
        end
        bus_write(acd_pkg::ADDR_CTRL, 8'h40);
        pulse_flags();
        rd(acd_pkg::ADDR_STATUS, stat());
        check("irq_n", 8'h01, {7'h00, irq_n});
        bus_write(acd_pkg::ADDR_CTRL, 8'hC0);
        pulse_flags();
        m_pend = 1'h1;
        m_err  = 1'h1;
        check("irq_n", 8'h00, {7'h00, irq_n});
        bus_write(acd_pkg::ADDR_CTRL, 8'h80);
        check("irq_n", 8'h01, {7'h00, irq_n});
        rd(acd_pkg::ADDR_STATUS, stat());
        bus_write(acd_pkg::ADDR_STATUS, 8'h00);
        m_pend = 1'h0;
        m_err  = 1'h0;
        rd(acd_pkg::ADDR_STATUS, stat());
        bus_read(16'h0088, d, oe);
        check("unmapped drive", 8'h00, {7'h00, oe});
        bus_write(16'h0088, 8'h55);
        rd(acd_pkg::ADDR_CTRL, 8'h80);
        reset <= 1'h1;
        repeat (3) @(posedge clock);
        reset <= 1'h0;
        model_reset();
        check_reset_state();
        final_report();
    end
endmodule : tb_app_control_data_registers
